// *** src/ltc_pkg.sv ***
// Constants for the per-channel test, loopback and interrupt-enable register set
`default_nettype none
package ltc_pkg;
   // Register indices inside one channel block; byte address = 4 * index
   localparam logic [3:0] REG_TERM     = 4'h1;
   localparam logic [3:0] REG_TPL      = 4'h2;
   localparam logic [3:0] REG_CIC      = 4'h3;
   localparam logic [3:0] REG_IEN      = 4'h4;
   localparam logic [3:0] REG_STS      = 4'h5;
   // Global register index
   localparam logic [7:0] REG_GLB      = 8'hE0;
   localparam int         IDX_LSB      = 2;
   localparam int         IDX_W        = 8;
   localparam logic [7:0] REG_RST      = 8'h00;
   // chan_test_power_loop_ctrl fields
   localparam int         QINV_BIT     = 7;
   localparam int         PAT_HI       = 6;
   localparam int         PAT_LO       = 4;
   localparam int         PWR_BIT      = 3;
   localparam int         LOOP_HI      = 2;
   localparam int         LOOP_LO      = 0;
   // chan_coding_insert_ctrl fields
   localparam int         CODE_BIT     = 5;
   localparam int         RES_HI       = 4;
   localparam int         RES_LO       = 3;
   localparam int         BPV_BIT      = 2;
   localparam int         BER_BIT      = 1;
   localparam int         RATIO_BIT    = 0;
   // chan_interrupt_enable and status fields share positions
   localparam int         DMO_BIT      = 6;
   localparam int         FLS_BIT      = 5;
   localparam int         LCV_BIT      = 4;
   localparam int         TERM_BIT     = 6;
   localparam int         GIE_BIT      = 0;
   // Pattern and loopback line_code_sel
   localparam logic [2:0] PAT_QRSS     = 3'h4;
   localparam logic [2:0] PAT_TAOS     = 3'h5;
   localparam logic [2:0] LOOP_DUAL    = 3'h4;
   localparam logic [2:0] LOOP_ANALOG  = 3'h5;
   localparam logic [2:0] LOOP_REMOTE  = 3'h6;
   localparam logic [2:0] LOOP_DIGITAL = 3'h7;
   // Error-insertion lanes
   localparam int         INS_BPV      = 0;
   localparam int         INS_BER      = 1;
   localparam int         INS_W        = 2;
endpackage
`default_nettype wire

// *** src/ltc_ins.sv ***
// Rising-edge detector for error-insertion bits, sampled on rising transmit clock edges
`default_nettype none
module ltc_ins #(
   parameter int W = 2
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         tx_clock_in_i,
   input  wire logic [W-1:0] req_i,
   output logic      [W-1:0] pulse_o
);
   logic         tx_clock_in_prev_r;
   logic [W-1:0] samp_r;
   logic         tx_clock_in_rise;

   assign tx_clock_in_rise = tx_clock_in_i & ~tx_clock_in_prev_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_clock_in_prev_r <= 1'b0;
      end else begin
         tx_clock_in_prev_r <= tx_clock_in_i;
      end
   end

   // R10: sample on transmit clock rise
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         samp_r <= '0;
      end else if (tx_clock_in_rise) begin
         samp_r <= req_i;
      end
   end

   // R8: one pulse per 0-to-1 change
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pulse_o <= '0;
      end else if (tx_clock_in_rise) begin
         pulse_o <= req_i & ~samp_r;
      end else begin
         pulse_o <= '0;
      end
   end
endmodule
`default_nettype wire

// *** src/ltc_regs.sv ***
// Per-channel control register set with APB slave, line controls and interrupt
// Notes on behaviour
// R1: QRSS inversion bit inverts transmitted QRSS
// R2: Pattern field: 0XX none, 100 QRSS, 101 all-ones
// R3: Transmitter power bits reset to off
// R4: Transmitter on needs bit and global pin
// R5: Loopback field selects dual, analog, remote, digital
// R6: Line code bit: AMI when 1, single rail
// R7: Two-bit field declares external receive resistor
// R8: Rising violation bit inserts one bipolar violation
// R9: Rising error bit inserts one bit error
// R10: Insertion bits sampled on transmit clock
// R11: Host writes 0 before writing 1
// R12: Ratio bit matters only with external termination
// R13: Driver monitor enable gates its interrupt
// R14: FIFO limit enable gates its interrupt
// R15: Violation/overflow enable gates its interrupt
// R16: Reserved bits are plain storage, reset 0; the TERM and global registers store only their one defined bit
// R17: Interrupt pin also needs global enable
// R18: Termination bit: 0 high-Z, 1 internal
// R19: Enabled active flags combine into one request
`default_nettype none
module ltc_regs #(
   parameter int NCH = 14,
   parameter int AW  = 12
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [AW-1:0]     paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              tx_global_enable_pin_i,
   input  wire logic              tx_clock_in_i,
   input  wire logic              single_rail_mode_i,
   input  wire logic [NCH-1:0]    driver_monitor_flag_i,
   input  wire logic [NCH-1:0]    fifo_limit_flag_i,
   input  wire logic [NCH-1:0]    violation_overflow_flag_i,
   output logic      [NCH-1:0]    tx_send_qrss_o,
   output logic      [NCH-1:0]    tx_send_taos_o,
   output logic      [NCH-1:0]    qrss_invert_o,
   output logic      [NCH-1:0]    tx_power_on_o,
   output logic      [NCH-1:0]    loop_dual_o,
   output logic      [NCH-1:0]    loop_analog_o,
   output logic      [NCH-1:0]    loop_remote_o,
   output logic      [NCH-1:0]    loop_digital_o,
   output logic      [NCH-1:0]    line_code_ami_o,
   output logic      [2*NCH-1:0]  rx_ext_resistor_sel_o,
   output logic      [NCH-1:0]    tx_termination_int_o,
   output logic      [NCH-1:0]    tx_ratio_1to2_o,
   output logic      [NCH-1:0]    insert_bipolar_violation_o,
   output logic      [NCH-1:0]    insert_bit_error_o,
   output logic                   irq_o
);
   localparam int IDX_W = ltc_pkg::IDX_W;

   logic [7:0]          tpl_r  [NCH];
   logic [7:0]          cic_r  [NCH];
   logic [7:0]          ien_r  [NCH];
   logic [NCH-1:0]      term_r;
   logic                gie_r;
   logic [NCH-1:0]      req;

   logic [IDX_W-1:0]    idx;
   logic [3:0]          ch;
   logic [3:0]          rsel;
   logic                hi_zero;
   logic                ch_ok;
   logic                is_glb;
   logic                mapped;
   logic                acc_go;
   logic                acc_done;
   logic [7:0]          rd_val;
   // Per-channel next values, gathered into one output flop process
   wire logic [NCH-1:0]   qrss_nxt;
   wire logic [NCH-1:0]   taos_nxt;
   wire logic [NCH-1:0]   qinv_nxt;
   wire logic [NCH-1:0]   pwr_nxt;
   wire logic [NCH-1:0]   ldual_nxt;
   wire logic [NCH-1:0]   lana_nxt;
   wire logic [NCH-1:0]   lrem_nxt;
   wire logic [NCH-1:0]   ldig_nxt;
   wire logic [NCH-1:0]   ami_nxt;
   wire logic [2*NCH-1:0] res_nxt;
   wire logic [NCH-1:0]   ratio_nxt;
   wire logic [NCH-1:0]   bpv_nxt;
   wire logic [NCH-1:0]   ber_nxt;

   assign idx     = paddr[ltc_pkg::IDX_LSB +: IDX_W];
   assign ch      = idx[7:4];
   assign rsel    = idx[3:0];
   assign hi_zero = (paddr >> (ltc_pkg::IDX_LSB + IDX_W)) == '0
                    && paddr[ltc_pkg::IDX_LSB-1:0] == '0;
   assign ch_ok   = 32'(ch) < NCH;
   assign is_glb  = idx == ltc_pkg::REG_GLB;
   assign mapped  = hi_zero && (is_glb || (ch_ok && rsel >= ltc_pkg::REG_TERM
                                           && rsel <= ltc_pkg::REG_STS));
   // Access phase first cycle computes answer, second completes
   assign acc_go   = psel & penable & ~pready;
   assign acc_done = psel & penable & pready;

   // Read mux
   always_comb begin
      rd_val = 8'h00;
      if (is_glb) begin
         rd_val[ltc_pkg::GIE_BIT] = gie_r;
      end else if (ch_ok) begin
         case (rsel)
            ltc_pkg::REG_TERM: rd_val[ltc_pkg::TERM_BIT] = term_r[ch];
            ltc_pkg::REG_TPL:  rd_val = tpl_r[ch];
            ltc_pkg::REG_CIC:  rd_val = cic_r[ch];
            ltc_pkg::REG_IEN:  rd_val = ien_r[ch];
            ltc_pkg::REG_STS: begin
               rd_val[ltc_pkg::DMO_BIT] = driver_monitor_flag_i[ch];
               rd_val[ltc_pkg::FLS_BIT] = fifo_limit_flag_i[ch];
               rd_val[ltc_pkg::LCV_BIT] = violation_overflow_flag_i[ch];
            end
            default: rd_val = 8'h00;
         endcase
      end
   end

   // APB answer: one wait state, then pready for one cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= acc_go;
         pslverr <= acc_go & ~mapped;
         if (acc_go && !pwrite && mapped) begin
            prdata <= {24'h00_0000, rd_val};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Register writes; R16: all eight bits of TPL, CIC and IEN stored, reserved included
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         // R3: power bits and everything else reset to 0
         for (int i = 0; i < NCH; i++) begin
            tpl_r[i] <= ltc_pkg::REG_RST;
            cic_r[i] <= ltc_pkg::REG_RST;
            ien_r[i] <= ltc_pkg::REG_RST;
         end
         term_r <= '0;
         gie_r  <= 1'b0;
      end else if (acc_done && pwrite && mapped) begin
         if (is_glb) begin
            gie_r <= pwdata[ltc_pkg::GIE_BIT];
         end else begin
            case (rsel)
               ltc_pkg::REG_TERM: term_r[ch] <= pwdata[ltc_pkg::TERM_BIT];
               ltc_pkg::REG_TPL:  tpl_r[ch]  <= pwdata[7:0];
               ltc_pkg::REG_CIC:  cic_r[ch]  <= pwdata[7:0];
               ltc_pkg::REG_IEN:  ien_r[ch]  <= pwdata[7:0];
               default: ;
            endcase
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         logic [2:0]              pat;
         logic [2:0]              lp;
         logic [ltc_pkg::INS_W-1:0] ins_req;
         logic [ltc_pkg::INS_W-1:0] ins_pls;

         assign pat = tpl_r[g][ltc_pkg::PAT_HI:ltc_pkg::PAT_LO];
         assign lp  = tpl_r[g][ltc_pkg::LOOP_HI:ltc_pkg::LOOP_LO];
         assign ins_req[ltc_pkg::INS_BPV] = cic_r[g][ltc_pkg::BPV_BIT];
         assign ins_req[ltc_pkg::INS_BER] = cic_r[g][ltc_pkg::BER_BIT];

         // R13 R14 R15 R19: masked flag combine
         assign req[g] = (driver_monitor_flag_i[g] & ien_r[g][ltc_pkg::DMO_BIT])
                       | (fifo_limit_flag_i[g] & ien_r[g][ltc_pkg::FLS_BIT])
                       | (violation_overflow_flag_i[g] & ien_r[g][ltc_pkg::LCV_BIT]);

         // R8 R9 R10: edge detect on transmit clock
         ltc_ins #(
            .W             (ltc_pkg::INS_W)
         ) u_ins (
            .clk_i         (clk_i),
            .rst_i         (rst_i),
            .tx_clock_in_i (tx_clock_in_i),
            .req_i         (ins_req),
            .pulse_o       (ins_pls)
         );

         // R2: reserved line_code_sel send nothing
         assign qrss_nxt[g]  = pat == ltc_pkg::PAT_QRSS;
         assign taos_nxt[g]  = pat == ltc_pkg::PAT_TAOS;
         // R1: invert only applies to QRSS
         assign qinv_nxt[g]  = tpl_r[g][ltc_pkg::QINV_BIT] & (pat == ltc_pkg::PAT_QRSS);
         // R4: bit and global pin
         assign pwr_nxt[g]   = tpl_r[g][ltc_pkg::PWR_BIT] & tx_global_enable_pin_i;
         // R5: loopback decode
         assign ldual_nxt[g] = lp == ltc_pkg::LOOP_DUAL;
         assign lana_nxt[g]  = lp == ltc_pkg::LOOP_ANALOG;
         assign lrem_nxt[g]  = lp == ltc_pkg::LOOP_REMOTE;
         assign ldig_nxt[g]  = lp == ltc_pkg::LOOP_DIGITAL;
         // R6: AMI in single rail only
         assign ami_nxt[g]   = cic_r[g][ltc_pkg::CODE_BIT] & single_rail_mode_i;
         // R7: resistor declaration
         assign res_nxt[2*g+:2] = cic_r[g][ltc_pkg::RES_HI:ltc_pkg::RES_LO];
         // R12: internal termination forces 1:2
         assign ratio_nxt[g] = term_r[g] | cic_r[g][ltc_pkg::RATIO_BIT];
         assign bpv_nxt[g]   = ins_pls[ltc_pkg::INS_BPV];
         assign ber_nxt[g]   = ins_pls[ltc_pkg::INS_BER];
      end
   endgenerate

   // Line control outputs, one flop process for all channels
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_send_qrss_o             <= '0;
         tx_send_taos_o             <= '0;
         qrss_invert_o              <= '0;
         tx_power_on_o              <= '0;
         loop_dual_o                <= '0;
         loop_analog_o              <= '0;
         loop_remote_o              <= '0;
         loop_digital_o             <= '0;
         line_code_ami_o            <= '0;
         rx_ext_resistor_sel_o      <= '0;
         tx_termination_int_o       <= '0;
         tx_ratio_1to2_o            <= '0;
         insert_bipolar_violation_o <= '0;
         insert_bit_error_o         <= '0;
      end else begin
         tx_send_qrss_o             <= qrss_nxt;
         tx_send_taos_o             <= taos_nxt;
         qrss_invert_o              <= qinv_nxt;
         tx_power_on_o              <= pwr_nxt;
         loop_dual_o                <= ldual_nxt;
         loop_analog_o              <= lana_nxt;
         loop_remote_o              <= lrem_nxt;
         loop_digital_o             <= ldig_nxt;
         line_code_ami_o            <= ami_nxt;
         rx_ext_resistor_sel_o      <= res_nxt;
         // R18: termination select
         tx_termination_int_o       <= term_r;
         tx_ratio_1to2_o            <= ratio_nxt;
         insert_bipolar_violation_o <= bpv_nxt;
         insert_bit_error_o         <= ber_nxt;
      end
   end

   // R17: global enable gates pin
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= gie_r & (|req);
      end
   end
endmodule
`default_nettype wire

// *** src/ltc_dummy_end.sv ***
// Unused
`default_nettype none
`default_nettype wire

// *** dv/ltc_apb_host.sv ***
// APB host model driving the register bus
`default_nettype none
module ltc_apb_host (
   input  wire logic        clk_i,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // One transfer, bounded wait on pready, one idle edge after
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output logic ok);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      ok = (pready === 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// *** dv/ltc_regs_props.sv ***
// Concurrent checks on the register set ports
`default_nettype none
module ltc_regs_props #(
   parameter int NCH = 14
) (
   input wire logic           clk_i,
   input wire logic           rst_i,
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pready,
   input wire logic           pslverr,
   input wire logic [31:0]    prdata,
   input wire logic           tx_global_enable_pin_i,
   input wire logic           tx_clock_in_i,
   input wire logic [NCH-1:0] driver_monitor_flag_i,
   input wire logic [NCH-1:0] fifo_limit_flag_i,
   input wire logic [NCH-1:0] violation_overflow_flag_i,
   input wire logic [NCH-1:0] tx_send_qrss_o,
   input wire logic [NCH-1:0] tx_send_taos_o,
   input wire logic [NCH-1:0] qrss_invert_o,
   input wire logic [NCH-1:0] tx_power_on_o,
   input wire logic [NCH-1:0] tx_termination_int_o,
   input wire logic [NCH-1:0] tx_ratio_1to2_o,
   input wire logic [NCH-1:0] insert_bipolar_violation_o,
   input wire logic [NCH-1:0] insert_bit_error_o,
   input wire logic           irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic any_flag = |(driver_monitor_flag_i | fifo_limit_flag_i | violation_overflow_flag_i);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_done;
      pready ##1 !pready;
   endsequence
   AST_ONE_WAIT: assert property (s_access |=> s_done)
      else $error("access not ended after one wait state");
   AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response without ready or with data");
   AST_INV_QRSS: assert property ((qrss_invert_o & ~tx_send_qrss_o) == '0)
      else $error("inversion active without qrss pattern");
   AST_PAT_EXCL: assert property ((tx_send_qrss_o & tx_send_taos_o) == '0)
      else $error("two patterns selected at once");
   AST_PWR_PIN: assert property (!$past(tx_global_enable_pin_i) |-> tx_power_on_o == '0)
      else $error("transmitter on while global pin low");
   AST_RATIO: assert property ((tx_termination_int_o & ~tx_ratio_1to2_o) == '0)
      else $error("internal termination without 1:2 ratio");
   AST_BPV_ONE: assert property ((insert_bipolar_violation_o & $past(insert_bipolar_violation_o)) == '0)
      else $error("violation pulse longer than one cycle");
   AST_BER_ONE: assert property ((insert_bit_error_o & $past(insert_bit_error_o)) == '0)
      else $error("bit error pulse longer than one cycle");
   AST_INS_TXCLK: assert property (|insert_bit_error_o |-> $past(tx_clock_in_i, 2))
      else $error("insertion without transmit clock rise");
   AST_IRQ_FLAG: assert property (!$past(any_flag) |-> !irq_o)
      else $error("interrupt without any alarm flag");
endmodule
bind ltc_regs ltc_regs_props #(.NCH(NCH)) u_props (.clk_i, .rst_i, .psel, .penable, .pready,
   .pslverr, .prdata, .tx_global_enable_pin_i, .tx_clock_in_i, .driver_monitor_flag_i,
   .fifo_limit_flag_i, .violation_overflow_flag_i, .tx_send_qrss_o, .tx_send_taos_o,
   .qrss_invert_o, .tx_power_on_o, .tx_termination_int_o, .tx_ratio_1to2_o,
   .insert_bipolar_violation_o, .insert_bit_error_o, .irq_o);
`default_nettype wire

// *** dv/liu_channel_test_loop_ctrl_tb_top.sv ***
// Self-checking bench for the channel control register set
`default_nettype none
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin errors++; \
   $display("mismatch at %0t got %h exp %h", $time, (g), (x)); end end
module liu_channel_test_loop_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 0, rst_i = 1, pin = 0, txc = 0, srm = 0;
   logic        psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [13:0] dmf = 0, flf = 0, vof = 0, qrss, taos, qinv, pwr, ld, la, lr, lg;
   logic [13:0] ami, term, r12, bpv, ber;
   logic [27:0] res;
   int          errors = 0, tests_run = 0;
   ltc_regs #(.NCH(14), .AW(12)) dut (.clk_i, .rst_i, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tx_global_enable_pin_i(pin), .tx_clock_in_i(txc),
      .single_rail_mode_i(srm), .driver_monitor_flag_i(dmf), .fifo_limit_flag_i(flf),
      .violation_overflow_flag_i(vof), .tx_send_qrss_o(qrss), .tx_send_taos_o(taos),
      .qrss_invert_o(qinv), .tx_power_on_o(pwr), .loop_dual_o(ld), .loop_analog_o(la),
      .loop_remote_o(lr), .loop_digital_o(lg), .line_code_ami_o(ami),
      .rx_ext_resistor_sel_o(res), .tx_termination_int_o(term), .tx_ratio_1to2_o(r12),
      .insert_bipolar_violation_o(bpv), .insert_bit_error_o(ber), .irq_o(irq));
   ltc_apb_host host (.clk_i, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
      .pwdata);
   initial forever #4 clk_i = ~clk_i;
   function automatic logic [11:0] ad(input int ch, input int r);
      return 12'((ch * 16 + r) * 4);
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e, ok;
      host.xfer(1'b1, a, {24'h0, d}, q, e, ok);
      `CHK(ok, 1'b1)
      if (ok !== 1'b1) summarize();
      repeat (2) @(posedge clk_i);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic xe);
      logic [31:0] q;
      logic        e, ok;
      host.xfer(1'b0, a, 32'h0, q, e, ok);
      `CHK({ok, e, q}, {1'b1, xe, 24'h0, x})
      if (ok !== 1'b1) summarize();
   endtask
   task automatic cnt(input int n, output int b, output int e);
      b = 0;
      e = 0;
      repeat (n) begin
         @(posedge clk_i);
         b += bpv[6];
         e += ber[6];
      end
   endtask
   task automatic t_reset();
      `CHK({pwr, irq}, 15'h0)
      for (int r = 2; r < 5; r++) begin
         rd(ad(0, r), 8'h00, 1'b0);
         rd(ad(13, r), 8'h00, 1'b0);
      end
      wr(12'h40B, 8'hFF);
      rd(12'h009, 8'h00, 1'b1);
      rd(12'h408, 8'h00, 1'b1);
      rd(ad(0, 2), 8'h00, 1'b0);
      $display("reset and refused done");
   endtask
   task automatic t_pattern();
      logic [2:0] c;
      pin <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         wr(ad(3, ltc_pkg::REG_TPL), {1'b1, c, 1'b1, c});
         `CHK({qrss[3], taos[3]}, {c == ltc_pkg::PAT_QRSS, c == ltc_pkg::PAT_TAOS})
         `CHK({qinv[3], pwr}, {c == ltc_pkg::PAT_QRSS, 14'h0008})
         `CHK({ld[3], la[3], lr[3], lg[3]}, 4'(i > 3 ? 8 >> (i - 4) : 0))
      end
      wr(ad(3, ltc_pkg::REG_TPL), 8'h48);
      `CHK({qrss[3], qinv[3]}, 2'b10)
      pin <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK(pwr, 14'h0)
      $display("pattern and loop done");
   endtask
   task automatic t_coding();
      for (int i = 0; i < 4; i++) begin
         srm <= i[0];
         wr(ad(1, ltc_pkg::REG_CIC), 8'(i * 8 + 8'hE0));
         rd(ad(1, ltc_pkg::REG_CIC), 8'(i * 8 + 8'hE0), 1'b0);
         `CHK({res[3:2], ami[1], r12[1]}, {2'(i), i[0], 1'b0})
      end
      wr(ad(1, ltc_pkg::REG_TERM), 8'h40);
      `CHK({term[1], r12[1]}, 2'b11)
      wr(ad(1, ltc_pkg::REG_TERM), 8'h00);
      wr(ad(1, ltc_pkg::REG_CIC), 8'h01);
      `CHK({term[1], r12[1], ami[1]}, 3'b010)
      $display("coding done");
   endtask
   task automatic t_insert();
      int b, e;
      wr(ad(6, ltc_pkg::REG_CIC), 8'h00);
      wr(ad(6, ltc_pkg::REG_CIC), 8'h06);
      cnt(4, b, e);
      `CHK(b + e, 0)
      txc <= 1'b1;
      cnt(8, b, e);
      `CHK({b, e}, {32'd1, 32'd1})
      txc <= 1'b0;
      cnt(4, b, e);
      txc <= 1'b1;
      cnt(8, b, e);
      `CHK(b + e, 0)
      $display("insert done");
   endtask
   task automatic t_irq();
      logic [7:0] m;
      for (int j = 4; j < 7; j++) begin
         m = 8'(1 << j);
         dmf <= {11'h0, m[6], 2'b0};
         flf <= {11'h0, m[5], 2'b0};
         vof <= {11'h0, m[4], 2'b0};
         wr(ad(2, ltc_pkg::REG_IEN), 8'h70);
         wr(12'(ltc_pkg::REG_GLB * 4), 8'h01);
         `CHK(irq, 1'b1)
         wr(ad(2, ltc_pkg::REG_IEN), 8'h70 ^ m);
         `CHK(irq, 1'b0)
         wr(ad(2, ltc_pkg::REG_IEN), 8'h70);
         wr(12'(ltc_pkg::REG_GLB * 4), 8'h00);
         `CHK(irq, 1'b0)
      end
      $display("interrupt enable done");
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_pattern();
      t_coding();
      t_insert();
      t_irq();
      summarize();
   end
endmodule
`default_nettype wire
